//--- pmic_status_checker_assertions.sv
// Checker of the status bank's two-wire target behaviour at its ports.
`timescale 1ns/1ps
module pmic_status_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    logic scl_q;
    logic sda_q;
    logic start_seen;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Counts clock rises since the last start so the address byte can be told apart.
    assign start_seen = scl && scl_q && sda_q && !sda_in;
    assign bit_cnt_next = start_seen ? 4'h0 :
        (scl && !scl_q && bit_cnt_reg != 4'hf) ? bit_cnt_reg + 4'h1 : bit_cnt_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            bit_cnt_reg <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
            bit_cnt_reg <= bit_cnt_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_drain_only: assert property (sda_out == 1'h0)
        else $error("data line driven high");
    a_reset_quiet: assert property ($fell(rst) |-> !sda_oe [*8])
        else $error("data line pulled right after reset");
    a_change_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("drive changed while clock high");
    a_hold_scl_high: assert property (scl && scl_q |-> $stable(sda_oe))
        else $error("drive not stable while clock high");
    a_start_released: assert property (start_seen |-> !sda_oe)
        else $error("start caused by device drive");
    a_stop_quiet: assert property (scl && scl_q && !sda_q && sda_in |=> !sda_oe [*4])
        else $error("device drives after stop");
    a_oe_stands: assert property ($fell(sda_oe) |-> $past(sda_oe, 2) && $past(sda_oe, 3))
        else $error("drive pulse too short");
    a_addr_quiet: assert property (bit_cnt_reg < 4'h8 |-> !sda_oe)
        else $error("device drives during address byte");
endmodule : pmic_status_checker

bind pmic_status_flag_registers pmic_status_checker i_checker (.clk(clk), .rst(rst), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

//--- pmic_status_flag_registers.sv
// Status and fault flag register bank with its two-wire target port.
`timescale 1ns/1ps
module pmic_status_flag_registers #(
    parameter logic [6:0] DEVICE_ADDRESS = pmic_status_pkg::DEFAULT_DEVICE_ADDRESS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [pmic_status_pkg::POWER_GOOD_WIDTH-1:0] power_good,
    input wire logic [pmic_status_pkg::FAULT_FIRST_WIDTH-1:0] regulation_lost_first,
    input wire logic [pmic_status_pkg::FAULT_SECOND_WIDTH-1:0] regulation_lost_second,
    input wire logic [pmic_status_pkg::TEMPERATURE_WIDTH-1:0] over_critical_temperature
);

    typedef enum logic [8:0] {
        ST_IDLE = 9'b000000001,
        ST_ADDR = 9'b000000010,
        ST_ADDR_ACK = 9'b000000100,
        ST_PTR = 9'b000001000,
        ST_PTR_ACK = 9'b000010000,
        ST_WR_DATA = 9'b000100000,
        ST_WR_ACK = 9'b001000000,
        ST_RD_DATA = 9'b010000000,
        ST_RD_ACK = 9'b100000000
    } link_state_e;

    generate
        if (DEVICE_ADDRESS[6:3] == 4'h0 || DEVICE_ADDRESS[6:3] == 4'hf) begin : g_bad_addr
            $error("DEVICE_ADDRESS lies in a reserved two-wire address group");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Link edge and condition detection.

    logic scl_reg;
    logic sda_reg;
    wire scl_rise = scl & ~scl_reg;
    wire scl_fall = ~scl & scl_reg;
    wire start_seen = scl & scl_reg & sda_reg & ~sda_in;
    wire stop_seen = scl & scl_reg & ~sda_reg & sda_in;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_reg <= scl;
            sda_reg <= sda_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Target state machine.

    link_state_e state_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [3:0] count_reg;
    logic [7:0] pointer_reg;
    logic read_mode_reg;
    logic host_nack_reg;
    logic sda_oe_reg;
    logic [7:0] read_value;

    wire byte_done = (count_reg == pmic_status_pkg::BITS_PER_BYTE);
    wire address_match = (shift_reg[7:1] == DEVICE_ADDRESS);
    wire receiving = (state_reg == ST_ADDR) | (state_reg == ST_PTR) | (state_reg == ST_WR_DATA);
    wire write_fire = (state_reg == ST_WR_DATA) & scl_fall & byte_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            count_reg <= 4'h0;
            pointer_reg <= 8'h00;
            read_mode_reg <= 1'b0;
            host_nack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (start_seen) begin
            state_reg <= ST_ADDR;
            count_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (stop_seen) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else if (scl_rise) begin
            if (receiving && !byte_done) begin
                shift_reg <= {shift_reg[6:0], sda_in};
                count_reg <= count_reg + 4'h1;
            end
            if (state_reg == ST_RD_ACK) begin
                host_nack_reg <= sda_in;
            end
        end else if (scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done) begin
                        count_reg <= 4'h0;
                        if (address_match) begin
                            state_reg <= ST_ADDR_ACK;
                            read_mode_reg <= shift_reg[0];
                            sda_oe_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (read_mode_reg) begin
                        state_reg <= ST_RD_DATA;
                        tx_reg <= read_value;
                        sda_oe_reg <= ~read_value[7];
                    end else begin
                        state_reg <= ST_PTR;
                        sda_oe_reg <= 1'b0;
                    end
                end
                ST_PTR: begin
                    if (byte_done) begin
                        pointer_reg <= shift_reg;
                        count_reg <= 4'h0;
                        state_reg <= ST_PTR_ACK;
                        sda_oe_reg <= 1'b1;
                    end
                end
                ST_PTR_ACK: begin
                    state_reg <= ST_WR_DATA;
                    sda_oe_reg <= 1'b0;
                end
                ST_WR_DATA: begin
                    if (byte_done) begin
                        count_reg <= 4'h0;
                        state_reg <= ST_WR_ACK;
                        sda_oe_reg <= 1'b1;
                    end
                end
                ST_WR_ACK: begin
                    pointer_reg <= pointer_reg + 8'h01;
                    state_reg <= ST_WR_DATA;
                    sda_oe_reg <= 1'b0;
                end
                ST_RD_DATA: begin
                    if (count_reg == 4'h7) begin
                        count_reg <= 4'h0;
                        pointer_reg <= pointer_reg + 8'h01;
                        state_reg <= ST_RD_ACK;
                        sda_oe_reg <= 1'b0;
                    end else begin
                        count_reg <= count_reg + 4'h1;
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_oe_reg <= ~tx_reg[6];
                    end
                end
                ST_RD_ACK: begin
                    if (host_nack_reg) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        state_reg <= ST_RD_DATA;
                        tx_reg <= read_value;
                        sda_oe_reg <= ~read_value[7];
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // The line is open drain: the target only ever pulls low.
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode and flag storage.

    wire hit_pg = (pointer_reg == pmic_status_pkg::RAIL_POWER_GOOD_SECOND_OFFSET);
    wire hit_f1 = (pointer_reg == pmic_status_pkg::RAIL_REGULATION_FAULT_FIRST_OFFSET);
    wire hit_f2 = (pointer_reg == pmic_status_pkg::RAIL_REGULATION_FAULT_SECOND_OFFSET);
    wire hit_tc = (pointer_reg == pmic_status_pkg::CRITICAL_TEMPERATURE_FLAGS_OFFSET);

    // Only the implemented low bits take a clear, so reserved bits ignore writes.
    wire [pmic_status_pkg::FAULT_FIRST_WIDTH-1:0] clear_first =
        {pmic_status_pkg::FAULT_FIRST_WIDTH{write_fire & hit_f1}} & shift_reg;
    wire [pmic_status_pkg::FAULT_SECOND_WIDTH-1:0] clear_second =
        {pmic_status_pkg::FAULT_SECOND_WIDTH{write_fire & hit_f2}}
        & shift_reg[pmic_status_pkg::FAULT_SECOND_WIDTH-1:0];
    wire [pmic_status_pkg::TEMPERATURE_WIDTH-1:0] clear_temperature =
        {pmic_status_pkg::TEMPERATURE_WIDTH{write_fire & hit_tc}}
        & shift_reg[pmic_status_pkg::TEMPERATURE_WIDTH-1:0];

    logic [pmic_status_pkg::POWER_GOOD_WIDTH-1:0] power_good_reg;
    logic [pmic_status_pkg::FAULT_FIRST_WIDTH-1:0] fault_first;
    logic [pmic_status_pkg::FAULT_SECOND_WIDTH-1:0] fault_second;
    logic [pmic_status_pkg::TEMPERATURE_WIDTH-1:0] temperature_flags;

    // Live power-good view, refreshed every cycle and never written by the host.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_good_reg <= pmic_status_pkg::RAIL_POWER_GOOD_SECOND_RESET[5:0];
        end else begin
            power_good_reg <= power_good;
        end
    end

    sticky_flag_bank #(
        .WIDTH(pmic_status_pkg::FAULT_FIRST_WIDTH)
    ) u_fault_first (
        .clk(clk),
        .rst(rst),
        .set_level(regulation_lost_first),
        .clear_pulse(clear_first),
        .flags(fault_first)
    );

    sticky_flag_bank #(
        .WIDTH(pmic_status_pkg::FAULT_SECOND_WIDTH)
    ) u_fault_second (
        .clk(clk),
        .rst(rst),
        .set_level(regulation_lost_second),
        .clear_pulse(clear_second),
        .flags(fault_second)
    );

    sticky_flag_bank #(
        .WIDTH(pmic_status_pkg::TEMPERATURE_WIDTH)
    ) u_temperature (
        .clk(clk),
        .rst(rst),
        .set_level(over_critical_temperature),
        .clear_pulse(clear_temperature),
        .flags(temperature_flags)
    );

    // Read selection; reserved upper bits and unmapped offsets read as zero.
    assign read_value =
        hit_pg ? {2'b00, power_good_reg} :
        hit_f1 ? fault_first :
        hit_f2 ? {3'b000, fault_second} :
        hit_tc ? {3'b000, temperature_flags} :
        pmic_status_pkg::UNMAPPED_READ_VALUE;

endmodule : pmic_status_flag_registers

//--- pmic_status_flag_registers_tb.sv
// Self-checking testbench of the status flag register bank.
`timescale 1ns/1ps
module pmic_status_flag_registers_tb;
    logic clk;
    logic rst;
    logic scl;
    logic sda_low;
    logic sda_oe;
    logic sda_in;
    logic [5:0] power_good = 6'h00;
    logic [7:0] regulation_lost_first = 8'h00;
    logic [4:0] regulation_lost_second = 5'h00;
    logic [4:0] over_critical_temperature = 5'h00;
    int n_mismatch = 0;
    int check_count = 0;
    assign sda_in = ~(sda_oe | sda_low);
    pmic_status_flag_registers i_pmic_status_flag_registers (.clk(clk), .rst(rst), .scl(scl),
        .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .power_good(power_good),
        .regulation_lost_first(regulation_lost_first),
        .regulation_lost_second(regulation_lost_second),
        .over_critical_temperature(over_critical_temperature));
    two_wire_host i_two_wire_host (.clk(clk), .sda_in(sda_in), .scl(scl), .sda_low(sda_low));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk
    task automatic rd1(input logic [7:0] ptr, input logic [7:0] exp, input string what);
        i_two_wire_host.read(ptr, 1);
        check("address acknowledge", 8'h01, {7'h00, i_two_wire_host.addr_ack});
        check(what, exp, i_two_wire_host.rbuf[0]);
    endtask : rd1
    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        i_two_wire_host.read(8'hb1, 5);
        for (int k = 0; k < 5; k++) begin
            check("reset value", 8'h00, i_two_wire_host.rbuf[k]);
        end
    endtask : t_reset_values
    task automatic t_power_good();
        power_good = 6'h2d;
        wait_clk(3);
        rd1(8'hb1, 8'h2d, "power good");
        i_two_wire_host.write(8'hb1, 8'hff);
        rd1(8'hb1, 8'h2d, "power good after write");
        power_good = 6'h12;
        wait_clk(3);
        rd1(8'hb1, 8'h12, "power good live");
    endtask : t_power_good
    task automatic t_fault_first();
        regulation_lost_first = 8'ha5;
        wait_clk(3);
        regulation_lost_first = 8'h04;
        rd1(8'hb2, 8'ha5, "first fault");
        i_two_wire_host.write(8'hb2, 8'h00);
        rd1(8'hb2, 8'ha5, "first fault after zero write");
        i_two_wire_host.write(8'hb2, 8'h81);
        rd1(8'hb2, 8'h24, "first fault partial clear");
        i_two_wire_host.write(8'hb2, 8'hff);
        rd1(8'hb2, 8'h04, "first fault cause present");
        regulation_lost_first = 8'h00;
        i_two_wire_host.write(8'hb2, 8'h04);
        rd1(8'hb2, 8'h00, "first fault cleared");
    endtask : t_fault_first
    task automatic t_fault_second();
        regulation_lost_second = 5'h1f;
        wait_clk(3);
        regulation_lost_second = 5'h00;
        i_two_wire_host.write(8'hb3, 8'he0);
        i_two_wire_host.read(8'hb2, 3);
        check("burst first fault", 8'h00, i_two_wire_host.rbuf[0]);
        check("second fault", 8'h1f, i_two_wire_host.rbuf[1]);
        check("burst temperature", 8'h00, i_two_wire_host.rbuf[2]);
        i_two_wire_host.write(8'hb3, 8'h0a);
        rd1(8'hb3, 8'h15, "second fault partial clear");
    endtask : t_fault_second
    task automatic t_temperature();
        for (int i = 0; i < 5; i++) begin
            over_critical_temperature = 5'h01 << i;
            wait_clk(3);
            over_critical_temperature = 5'h00;
            rd1(8'hb4, 8'h01 << i, "temperature flag");
            i_two_wire_host.write(8'hb4, 8'he0 | (8'h01 << i));
            rd1(8'hb4, 8'h00, "temperature cleared");
        end
    endtask : t_temperature
    task automatic t_foreign_address();
        regulation_lost_second = 5'h01;
        wait_clk(3);
        regulation_lost_second = 5'h00;
        i_two_wire_host.addr = pmic_status_pkg::DEFAULT_DEVICE_ADDRESS ^ 7'h01;
        i_two_wire_host.write(8'hb3, 8'h01);
        check("foreign acknowledge", 8'h00, {7'h00, i_two_wire_host.addr_ack});
        i_two_wire_host.addr = pmic_status_pkg::DEFAULT_DEVICE_ADDRESS;
        rd1(8'hb3, 8'h15, "fault after foreign write");
    endtask : t_foreign_address
    // Sets every fault and temperature flag with power good held low, then resets in mid-run and expects the whole bank back at zero.
    task automatic t_mid_reset();
        power_good = 6'h00;
        regulation_lost_first = 8'hff;
        regulation_lost_second = 5'h1f;
        over_critical_temperature = 5'h1f;
        wait_clk(3);
        regulation_lost_first = 8'h00;
        regulation_lost_second = 5'h00;
        over_critical_temperature = 5'h00;
        rst = 1'h1;
        wait_clk(2);
        rst = 1'h0;
        wait_clk(5);
        i_two_wire_host.read(8'hb1, 4);
        check("power good after reset", 8'h00, i_two_wire_host.rbuf[0]);
        check("first fault after reset", 8'h00, i_two_wire_host.rbuf[1]);
        check("second fault after reset", 8'h00, i_two_wire_host.rbuf[2]);
        check("temperature after reset", 8'h00, i_two_wire_host.rbuf[3]);
    endtask : t_mid_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'h1;
        wait_clk(20);
        rst = 1'h0;
        wait_clk(5);
        t_reset_values();
        t_power_good();
        t_fault_first();
        t_fault_second();
        t_temperature();
        t_foreign_address();
        t_mid_reset();
        conclude();
    end
    initial begin
        #1500000;
        n_mismatch++;
        conclude();
    end
endmodule : pmic_status_flag_registers_tb

//--- pmic_status_pkg.sv
// Package with register offsets, field layouts, reset values and link constants of the status bank.
package pmic_status_pkg;

    // Register offsets on the two-wire link.
    localparam logic [7:0] RAIL_POWER_GOOD_SECOND_OFFSET = 8'hb1;
    localparam logic [7:0] RAIL_REGULATION_FAULT_FIRST_OFFSET = 8'hb2;
    localparam logic [7:0] RAIL_REGULATION_FAULT_SECOND_OFFSET = 8'hb3;
    localparam logic [7:0] CRITICAL_TEMPERATURE_FLAGS_OFFSET = 8'hb4;

    // Reset values.
    localparam logic [7:0] RAIL_POWER_GOOD_SECOND_RESET = 8'h00;
    localparam logic [7:0] RAIL_REGULATION_FAULT_FIRST_RESET = 8'h00;
    localparam logic [7:0] RAIL_REGULATION_FAULT_SECOND_RESET = 8'h00;
    localparam logic [7:0] CRITICAL_TEMPERATURE_FLAGS_RESET = 8'h00;

    // Implemented field widths; the bits above read as zero.
    localparam int POWER_GOOD_WIDTH = 6;
    localparam int FAULT_FIRST_WIDTH = 8;
    localparam int FAULT_SECOND_WIDTH = 5;
    localparam int TEMPERATURE_WIDTH = 5;

    // Power-good bit positions.
    localparam int PG_FIVE_VOLT_REGULATOR_BIT = 5;
    localparam int PG_LINEAR_REGULATOR_A_ONE_BIT = 4;
    localparam int PG_TERMINATION_REGULATOR_BIT = 3;
    localparam int PG_SWITCH_B_TWO_BIT = 2;
    localparam int PG_SWITCH_B_ONE_BIT = 1;
    localparam int PG_LINEAR_REGULATOR_A_THREE_BIT = 0;

    // First fault register bit positions; step-down rails occupy bits 5 down to 0.
    localparam int F1_LINEAR_REGULATOR_A_TWO_BIT = 7;
    localparam int F1_SWITCH_A_ONE_BIT = 6;
    localparam int F1_STEP_DOWN_RAIL_SIX_BIT = 5;
    localparam int F1_STEP_DOWN_RAIL_ONE_BIT = 0;

    // Second fault register bit positions.
    localparam int F2_LINEAR_REGULATOR_A_ONE_BIT = 4;
    localparam int F2_TERMINATION_REGULATOR_BIT = 3;
    localparam int F2_SWITCH_B_TWO_BIT = 2;
    localparam int F2_SWITCH_B_ONE_BIT = 1;
    localparam int F2_LINEAR_REGULATOR_A_THREE_BIT = 0;

    // Critical temperature flag bit positions.
    localparam int REST_OF_DIE_OVERHEAT_FLAG_BIT = 4;
    localparam int TERMINATION_OVERHEAT_FLAG_BIT = 3;
    localparam int UPPER_RIGHT_OVERHEAT_FLAG_BIT = 2;
    localparam int UPPER_LEFT_OVERHEAT_FLAG_BIT = 1;
    localparam int LOWER_RIGHT_OVERHEAT_FLAG_BIT = 0;

    // Link constants.
    localparam logic [6:0] DEFAULT_DEVICE_ADDRESS = 7'h5e;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : pmic_status_pkg

//--- sticky_flag_bank.sv
// Bank of sticky event flags with write-one-to-clear and set priority.
`timescale 1ns/1ps
module sticky_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set_level,
    input wire logic [WIDTH-1:0] clear_pulse,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    generate
        if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
            $error("sticky_flag_bank width must lie between 1 and 8");
        end
    endgenerate

    // A cause present in the clearing cycle keeps the flag set.
    assign flags_next = set_level | (flags_reg & ~clear_pulse);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule : sticky_flag_bank

//--- two_wire_host.sv
// Two-wire host model that reads and clears the status bank.
`timescale 1ns/1ps
module two_wire_host #(
    parameter int HALF = 5
) (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_low
);
    logic [7:0] rbuf [0:4];
    logic [6:0] addr = pmic_status_pkg::DEFAULT_DEVICE_ADDRESS;
    logic addr_ack;
    logic ack;
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic tick();
        repeat (HALF) @(posedge clk);
        #1;
    endtask : tick
    task automatic start();
        sda_low = 1'h0;
        tick();
        scl = 1'h1;
        tick();
        sda_low = 1'h1;
        tick();
        scl = 1'h0;
        tick();
    endtask : start
    task automatic stop();
        sda_low = 1'h1;
        tick();
        scl = 1'h1;
        tick();
        sda_low = 1'h0;
        tick();
    endtask : stop
    // Released bits let the wire float to the pull-up level.
    task automatic clock_bit(input logic b, output logic seen);
        sda_low = ~b;
        tick();
        scl = 1'h1;
        tick();
        seen = sda_in;
        scl = 1'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask : clock_bit
    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
        clock_bit(1'h1, s);
        ack = ~s;
    endtask : send_byte
    task automatic write(input logic [7:0] ptr, input logic [7:0] data);
        start();
        send_byte({addr, 1'h0});
        addr_ack = ack;
        send_byte(ptr);
        send_byte(data);
        stop();
    endtask : write
    // The last byte of a read gets no acknowledge, as the protocol wants.
    task automatic read(input logic [7:0] ptr, input int n);
        logic s;
        start();
        send_byte({addr, 1'h0});
        addr_ack = ack;
        send_byte(ptr);
        start();
        send_byte({addr, 1'h1});
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) clock_bit(1'h1, rbuf[k][i]);
            clock_bit(k == n - 1, s);
        end
        stop();
    endtask : read
endmodule : two_wire_host
